// ===== smc_stop_ctrl.sv
// Stop-mode controller: mode choice, clock and power gating, wake and debug handling.
//
// Behaviour
// - debug enabled at stop entry keeps debug logic clocks running.
// - debug enabled at stop entry keeps regulator in full regulation.
// - stop2 request with debug enabled enters stop3 instead.
// - status-type debug memory accesses in stop are refused with error.
// - background command in stop wakes into background mode when debug enabled.
// - background mode entered from stop accepts every debug command.
// - low-voltage detect plus in-stop enable keep regulator active in stop.
// - stop2 request with low-voltage detect in stop enters stop3.
// - any stop mode halts all peripheral clocks, debug enabled or not.
// - stop2 latches pins on the entry edge; stop3 leaves pins held by logic.
// - stop3 retains RAM and all register contents.
// - stop2 wake resets registers, keeps RAM, holds pins until acknowledge.
// - stop3 puts clock generator in standby unless debug enabled; oscillator runs if enabled.
// - stop2 powers clock generator off, oscillator stops, reset on wake.
// - converter standby in stop2, and in stop3 unless async clock; stop2 wake resets it.
// - keypad unit wakes from stop3; disabled in stop2 and reset after.
// - timer and serial units halt in stop; reset after stop2 wake.
// - regulator standby in stop unless low-voltage-in-stop or debug enabled.
// - stop with stop disallowed forces illegal-opcode reset, no stop entry.
// - mode select bit one picks stop2, zero picks stop3.
// - stop2 wake sets power-down flag; writing acknowledge one clears and opens.
// - stop3 exits on reset pin or periodic, voltage, converter, pin, keypad, serial interrupt.
//
// The implementer's own choices: register access over Wishbone and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module smc_stop_ctrl
  import smc_pkg::*;
#(
  parameter int ADR_W = 4
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_b,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // CPU side.
  input wire logic stopExec,
  output logic cpuRun_q,
  output logic illegalOpReset_q,
  output logic wakeIrq_q,
  output logic sysReset_q,
  // Wake sources.
  input wire logic resetPinWake,
  input wire logic periodicWakeIrq,
  input wire logic lowvoltIrq,
  input wire logic converterIrq,
  input wire logic extPinIrq,
  input wire logic keypadIrq,
  input wire logic asyncSerialIrq,
  // Debug side.
  input wire logic dbgBackgroundCmd,
  input wire logic dbgStatusAccess,
  input wire logic dbgGoCmd,
  output logic dbgClkEn_q,
  output logic dbgAllCmdsEn_q,
  output logic dbgMemGrant_q,
  output logic dbgStatusErr_q,
  // Power and peripheral controls.
  output logic periphClkEn_q,
  output logic regulatorStandby_q,
  output logic clkGenStandby_q,
  output logic clkGenOff_q,
  output logic oscRun_q,
  output logic converterStandby_q,
  output logic keypadWakeEn_q,
  output logic pinLatch_q
);

  initial begin
    if (ADR_W < 4) begin
      $error("ADR_W must be at least 4");
    end
  end

  localparam int RST_W = $clog2(SMC_WAKE_RST_CYC + 1);
  localparam logic [RST_W-1:0] RST_LOAD = RST_W'(SMC_WAKE_RST_CYC);

  logic rstMeta_q;
  logic rstSync_q;
  logic [6:0] ctrl_q;
  logic pdFlag_q;
  logic dbgAtStop_q;
  logic lvdAtStop_q;
  logic oscAtStop_q;
  logic adcAtStop_q;
  logic [RST_W-1:0] rstCnt_q;
  logic [RST_W-1:0] rstCnt_d;
  smc_state_t state_q;
  smc_state_t state_d;
  logic busReq;
  logic ctrlWr;
  logic ackWr;
  logic stop2Wake;
  logic stop3Wake;
  logic bkgdWake;
  logic lvdStop;
  logic enterStop2;
  logic illegalStop;
  logic [7:0] statVal;
  logic stopEntry;
  logic awakeNext;

  // Reset release through two flip-flops.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign ctrlWr = busReq && wb_we_i && wb_sel_i[0] && (wb_adr_i[3:0] == SMC_OFS_CTRL);
  assign ackWr = ctrlWr && wb_dat_i[SMC_CTL_PD_ACK];
  assign lvdStop = ctrl_q[SMC_CTL_LVD_EN] && ctrl_q[SMC_CTL_LVD_STOP];
  assign illegalStop = stopExec && (state_q == SMC_RUN) && !ctrl_q[SMC_CTL_STOP_ALLOW];
  // mode select, debug override, voltage override
  assign enterStop2 = ctrl_q[SMC_CTL_PPD_SEL] && !ctrl_q[SMC_CTL_DBG_EN] && !lvdStop;
  // stop3 wake sources, keypad wakes stop3
  assign stop3Wake = resetPinWake || periodicWakeIrq || lowvoltIrq || converterIrq
                     || extPinIrq || keypadIrq || asyncSerialIrq;
  assign stop2Wake = resetPinWake || periodicWakeIrq || extPinIrq;
  assign bkgdWake = dbgBackgroundCmd && dbgAtStop_q;
  assign stopEntry = (state_q == SMC_RUN) && (state_d != SMC_RUN);
  assign awakeNext = (state_d == SMC_RUN) || (state_d == SMC_BKGD);

  // Status word placed by the package field positions.
  always_comb begin
    statVal = 8'h00;
    statVal[SMC_STA_PD_FLAG] = pdFlag_q;
    statVal[SMC_STA_MODE_LO] = (state_q == SMC_STOP3);
    statVal[SMC_STA_MODE_LO + 1] = (state_q == SMC_STOP2);
    statVal[SMC_STA_BKGD] = (state_q == SMC_BKGD);
    statVal[SMC_STA_LATCH] = pinLatch_q;
  end

  // single priority decision on the state
  always_comb begin
    state_d = state_q;
    case (state_q)
      SMC_RUN: begin
        if (stopExec && ctrl_q[SMC_CTL_STOP_ALLOW]) begin
          state_d = enterStop2 ? SMC_STOP2 : SMC_STOP3;
        end
      end
      SMC_STOP3: begin
        if (resetPinWake || stop3Wake) begin
          state_d = SMC_RUN;
        end else if (bkgdWake) begin
          state_d = SMC_BKGD;
        end
      end
      SMC_STOP2: begin
        if (stop2Wake) begin
          state_d = SMC_RUN;
        end
      end
      SMC_BKGD: begin
        if (dbgGoCmd) begin
          state_d = SMC_RUN;
        end
      end
      default: state_d = SMC_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      state_q <= SMC_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      dbgAtStop_q <= 1'b0;
      lvdAtStop_q <= 1'b0;
      oscAtStop_q <= 1'b0;
      adcAtStop_q <= 1'b0;
    end else if (stopExec && state_q == SMC_RUN) begin
      dbgAtStop_q <= ctrl_q[SMC_CTL_DBG_EN];
      lvdAtStop_q <= lvdStop;
      oscAtStop_q <= ctrl_q[SMC_CTL_OSC_STOP];
      adcAtStop_q <= ctrl_q[SMC_CTL_ADC_ACLK];
    end
  end

  // Control register; a system reset pulse returns it to defaults.
  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      ctrl_q <= SMC_CTL_RESET;
    end else if (sysReset_q) begin
      ctrl_q <= SMC_CTL_RESET;
    end else if (ctrlWr) begin
      ctrl_q <= wb_dat_i[6:0];
    end
  end

  // The flag survives the wake reset; a wake that meets an acknowledge wins.
  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      pdFlag_q <= 1'b0;
    end else if (state_q == SMC_STOP2 && stop2Wake) begin
      pdFlag_q <= 1'b1;
    end else if (ackWr) begin
      pdFlag_q <= 1'b0;
    end
  end

  // pin latch closes on stop2 entry, opens on acknowledge
  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      pinLatch_q <= 1'b0;
    end else if (state_d == SMC_STOP2) begin
      pinLatch_q <= 1'b1;
    end else if (ackWr) begin
      pinLatch_q <= 1'b0;
    end
  end

  // wake reset pulse, peripheral reset, converter reset
  always_comb begin
    rstCnt_d = rstCnt_q;
    if ((state_q == SMC_STOP2 && stop2Wake) || (state_q == SMC_STOP3 && resetPinWake)) begin
      rstCnt_d = RST_LOAD;
    end else if (rstCnt_q != '0) begin
      rstCnt_d = rstCnt_q - RST_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      rstCnt_q <= '0;
      sysReset_q <= 1'b0;
    end else begin
      rstCnt_q <= rstCnt_d;
      sysReset_q <= (rstCnt_d != '0);
    end
  end

  // CPU events.
  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      cpuRun_q <= 1'b1;
      illegalOpReset_q <= 1'b0;
      wakeIrq_q <= 1'b0;
    end else begin
      cpuRun_q <= (state_d == SMC_RUN);
      illegalOpReset_q <= illegalStop;
      // stop3 interrupt wake resumes with state kept
      wakeIrq_q <= (state_q == SMC_STOP3) && stop3Wake && !resetPinWake;
    end
  end

  // Debug command handling.
  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      dbgClkEn_q <= 1'b1;
      dbgAllCmdsEn_q <= 1'b0;
      dbgMemGrant_q <= 1'b0;
      dbgStatusErr_q <= 1'b0;
    end else begin
      dbgClkEn_q <= (state_d == SMC_RUN) || (state_d == SMC_BKGD)
                    || (state_d == SMC_STOP3 && dbgAtStop_q)
                    || (state_q == SMC_RUN && ctrl_q[SMC_CTL_DBG_EN]);
      // full command set in background mode
      dbgAllCmdsEn_q <= (state_d == SMC_BKGD);
      dbgStatusErr_q <= dbgStatusAccess && (state_q == SMC_STOP3 || state_q == SMC_STOP2);
      dbgMemGrant_q <= dbgStatusAccess && (state_q == SMC_RUN || state_q == SMC_BKGD);
    end
  end

  // Power, clock and peripheral controls follow the next state.
  // peripheral clocks halt
  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      periphClkEn_q <= 1'b1;
    end else begin
      periphClkEn_q <= awakeNext;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      regulatorStandby_q <= 1'b0;
    end else if (stopEntry) begin
      regulatorStandby_q <= !ctrl_q[SMC_CTL_DBG_EN] && !lvdStop;
    end else if (awakeNext) begin
      regulatorStandby_q <= 1'b0;
    end else begin
      regulatorStandby_q <= !dbgAtStop_q && !lvdAtStop_q;
    end
  end

  // clock generator standby in stop3 unless debug enabled, off in stop2
  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      clkGenStandby_q <= 1'b0;
      clkGenOff_q <= 1'b0;
    end else if (stopEntry) begin
      clkGenStandby_q <= !enterStop2 && !ctrl_q[SMC_CTL_DBG_EN];
      clkGenOff_q <= enterStop2;
    end else if (awakeNext) begin
      clkGenStandby_q <= 1'b0;
      clkGenOff_q <= 1'b0;
    end
  end

  // oscillator kept only if enabled or debug enabled, never in stop2
  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      oscRun_q <= 1'b1;
    end else if (stopEntry) begin
      oscRun_q <= !enterStop2 && (ctrl_q[SMC_CTL_OSC_STOP] || ctrl_q[SMC_CTL_DBG_EN]);
    end else if (awakeNext) begin
      oscRun_q <= 1'b1;
    end else begin
      oscRun_q <= (state_q == SMC_STOP3) && (oscAtStop_q || dbgAtStop_q);
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      converterStandby_q <= 1'b0;
    end else if (stopEntry) begin
      converterStandby_q <= enterStop2 || !ctrl_q[SMC_CTL_ADC_ACLK];
    end else if (awakeNext) begin
      converterStandby_q <= 1'b0;
    end else begin
      converterStandby_q <= (state_q == SMC_STOP2) || !adcAtStop_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      keypadWakeEn_q <= 1'b0;
    end else if (stopEntry) begin
      keypadWakeEn_q <= !enterStop2;
    end else if (awakeNext) begin
      keypadWakeEn_q <= 1'b0;
    end
  end

  // Bus answer one cycle after the request; unmapped reads give zero.
  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= busReq;
      if (busReq && !wb_we_i) begin
        case (wb_adr_i[3:0])
          SMC_OFS_CTRL: wb_dat_o <= {25'h0, ctrl_q};
          SMC_OFS_STAT: wb_dat_o <= {24'h0, statVal};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ===== smc_pkg.sv
// Shared constants for the stop-mode controller.
package smc_pkg;
  // Register byte offsets.
  localparam logic [3:0] SMC_OFS_CTRL = 4'h0;
  localparam logic [3:0] SMC_OFS_STAT = 4'h4;
  // Control register field positions.
  localparam int SMC_CTL_STOP_ALLOW = 0;
  localparam int SMC_CTL_PPD_SEL = 1;
  localparam int SMC_CTL_DBG_EN = 2;
  localparam int SMC_CTL_LVD_EN = 3;
  localparam int SMC_CTL_LVD_STOP = 4;
  localparam int SMC_CTL_OSC_STOP = 5;
  localparam int SMC_CTL_ADC_ACLK = 6;
  localparam int SMC_CTL_PD_ACK = 7;
  localparam logic [6:0] SMC_CTL_RESET = 7'h00;
  // Status register field positions.
  localparam int SMC_STA_PD_FLAG = 0;
  localparam int SMC_STA_MODE_LO = 1;
  localparam int SMC_STA_BKGD = 3;
  localparam int SMC_STA_LATCH = 4;
  // Length of the system reset pulse after a stop2 or pin wake.
  localparam int SMC_WAKE_RST_CYC = 4;
  typedef enum logic [1:0] {SMC_RUN, SMC_STOP3, SMC_STOP2, SMC_BKGD} smc_state_t;
endpackage

// ===== smc_cpu_model.sv
// Model of the CPU core and the debug host facing the controller.
`timescale 1ns/100ps
`default_nettype none
module smc_cpu_model (
  // Clock and bench requests.
  input wire logic clk_sys,
  input wire logic [3:0] req,
  input wire logic cpuRun_q,
  // Pulses to the controller.
  output logic stopExec,
  output logic dbgStatusAccess,
  output logic dbgBackgroundCmd,
  output logic dbgGoCmd
);
  // A halted core fetches nothing, so stop is only issued while it runs.
  always @(posedge clk_sys) begin
    stopExec <= req[0] && cpuRun_q;
    dbgStatusAccess <= req[1];
    dbgBackgroundCmd <= req[2];
    dbgGoCmd <= req[3];
  end
endmodule
`default_nettype wire

// ===== smc_stop_ctrl_chk.sv
// Assertion checker bound to the stop-mode controller.
`timescale 1ns/100ps
`default_nettype none
module smc_stop_ctrl_chk (
  // Clock, reset and bus.
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Stop, wake and debug.
  input wire logic keypadIrq,
  input wire logic dbgBackgroundCmd,
  input wire logic dbgStatusAccess,
  input wire logic cpuRun_q,
  input wire logic illegalOpReset_q,
  input wire logic sysReset_q,
  input wire logic dbgClkEn_q,
  input wire logic dbgAllCmdsEn_q,
  input wire logic dbgStatusErr_q,
  input wire logic periphClkEn_q,
  input wire logic regulatorStandby_q,
  input wire logic clkGenOff_q,
  input wire logic oscRun_q,
  input wire logic pinLatch_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire logic inStop = !cpuRun_q && !dbgAllCmdsEn_q;
  a_bus_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack is not a single pulse");
  a_status_refuse: assert property (inStop && dbgStatusAccess |=> dbgStatusErr_q)
    else $error("status access in stop not refused");
  a_periph_halt: assert property (inStop |-> !periphClkEn_q)
    else $error("peripheral clock running in stop");
  a_dbg_stop3: assert property (inStop && dbgClkEn_q |-> !regulatorStandby_q && !clkGenOff_q)
    else $error("debug stop not held in stop3 with full regulation");
  a_stop2_pins: assert property (clkGenOff_q |-> pinLatch_q && !oscRun_q && !dbgClkEn_q)
    else $error("stop2 without latched pins or with oscillator");
  a_wake_reset: assert property ($rose(sysReset_q) |-> sysReset_q[*4] ##1 !sysReset_q)
    else $error("wake reset not four cycles");
  a_stop2_exit: assert property ($fell(clkGenOff_q) |-> sysReset_q && pinLatch_q && cpuRun_q)
    else $error("stop2 exit without reset or latch");
  a_keypad_wake: assert property (inStop && !clkGenOff_q && keypadIrq |=> cpuRun_q)
    else $error("keypad did not wake stop3");
  a_illegal_run: assert property (illegalOpReset_q |-> cpuRun_q && periphClkEn_q)
    else $error("stop entered while disallowed");
  a_bkgd_entry: assert property ($rose(dbgAllCmdsEn_q) |-> $past(dbgBackgroundCmd) && dbgClkEn_q)
    else $error("background mode without command");
endmodule
bind smc_stop_ctrl smc_stop_ctrl_chk uChk (
  .clk_sys(clk_sys),
  .rst_b(rst_b),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o),
  .keypadIrq(keypadIrq),
  .dbgBackgroundCmd(dbgBackgroundCmd),
  .dbgStatusAccess(dbgStatusAccess),
  .cpuRun_q(cpuRun_q),
  .illegalOpReset_q(illegalOpReset_q),
  .sysReset_q(sysReset_q),
  .dbgClkEn_q(dbgClkEn_q),
  .dbgAllCmdsEn_q(dbgAllCmdsEn_q),
  .dbgStatusErr_q(dbgStatusErr_q),
  .periphClkEn_q(periphClkEn_q),
  .regulatorStandby_q(regulatorStandby_q),
  .clkGenOff_q(clkGenOff_q),
  .oscRun_q(oscRun_q),
  .pinLatch_q(pinLatch_q)
);
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the stop-mode controller.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import smc_pkg::*;
  logic clk_sys = 1'h0, rst_b = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf, req = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [6:0] wk = 7'h00;
  logic rstPrev = 1'h0;
  int miscompares = 0, num_checks = 0, cycles = 0, nWake = 0, nRst = 0, nErr = 0, nGrant = 0, nIll = 0;
  wire logic [31:0] wb_dat_o;
  wire logic wb_ack_o, stopExec, dbgStatusAccess, dbgBackgroundCmd, dbgGoCmd;
  wire logic cpuRun_q, illegalOpReset_q, wakeIrq_q, sysReset_q, dbgClkEn_q, dbgAllCmdsEn_q;
  wire logic dbgMemGrant_q, dbgStatusErr_q, periphClkEn_q, regulatorStandby_q, clkGenStandby_q;
  wire logic clkGenOff_q, oscRun_q, converterStandby_q, keypadWakeEn_q, pinLatch_q;
  wire logic resetPinWake = wk[6], periodicWakeIrq = wk[5], lowvoltIrq = wk[4];
  wire logic converterIrq = wk[3], extPinIrq = wk[2], keypadIrq = wk[1], asyncSerialIrq = wk[0];
  wire logic [9:0] outs = {cpuRun_q, periphClkEn_q, pinLatch_q, clkGenOff_q, clkGenStandby_q,
    oscRun_q, regulatorStandby_q, converterStandby_q, keypadWakeEn_q, dbgClkEn_q};
  logic [7:0] cfg [3] = '{8'h07, 8'h1b, 8'h61};
  logic [9:0] expOut [3] = '{10'h017, 10'h026, 10'h03a};
  smc_stop_ctrl DUT (.clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .stopExec(stopExec),
    .cpuRun_q(cpuRun_q), .illegalOpReset_q(illegalOpReset_q), .wakeIrq_q(wakeIrq_q),
    .sysReset_q(sysReset_q), .resetPinWake(resetPinWake), .periodicWakeIrq(periodicWakeIrq),
    .lowvoltIrq(lowvoltIrq), .converterIrq(converterIrq), .extPinIrq(extPinIrq),
    .keypadIrq(keypadIrq), .asyncSerialIrq(asyncSerialIrq),
    .dbgBackgroundCmd(dbgBackgroundCmd), .dbgStatusAccess(dbgStatusAccess),
    .dbgGoCmd(dbgGoCmd), .dbgClkEn_q(dbgClkEn_q), .dbgAllCmdsEn_q(dbgAllCmdsEn_q),
    .dbgMemGrant_q(dbgMemGrant_q), .dbgStatusErr_q(dbgStatusErr_q),
    .periphClkEn_q(periphClkEn_q), .regulatorStandby_q(regulatorStandby_q),
    .clkGenStandby_q(clkGenStandby_q), .clkGenOff_q(clkGenOff_q), .oscRun_q(oscRun_q),
    .converterStandby_q(converterStandby_q), .keypadWakeEn_q(keypadWakeEn_q),
    .pinLatch_q(pinLatch_q));
  smc_cpu_model uCpu (.clk_sys(clk_sys), .req(req), .cpuRun_q(cpuRun_q), .stopExec(stopExec),
    .dbgStatusAccess(dbgStatusAccess), .dbgBackgroundCmd(dbgBackgroundCmd), .dbgGoCmd(dbgGoCmd));
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    rstPrev <= sysReset_q;
    nWake <= nWake + int'(wakeIrq_q === 1'h1);
    nRst <= nRst + int'(sysReset_q === 1'h1 && rstPrev === 1'h0);
    nErr <= nErr + int'(dbgStatusErr_q === 1'h1);
    nGrant <= nGrant + int'(dbgMemGrant_q === 1'h1);
    nIll <= nIll + int'(illegalOpReset_q === 1'h1);
    if (cycles == 3000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [31:0] r;
    @(posedge clk_sys);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do @(posedge clk_sys); while (wb_ack_o !== 1'h1);
    r = wb_dat_o;
    q = r[7:0];
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'h0, a, 8'h00, q);
    check({2'h0, q}, {2'h0, e});
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'h1, a, d, q);
  endtask
  task automatic go(input int i);
    @(posedge clk_sys);
    req[i] <= 1'h1;
    @(posedge clk_sys);
    req <= 4'h0;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task automatic wake(input int j);
    @(posedge clk_sys);
    wk[j] <= 1'h1;
    @(posedge clk_sys);
    wk <= 7'h00;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'h1;
    repeat (4) @(posedge clk_sys);
    rd(SMC_OFS_CTRL, 8'h00);
    rd(SMC_OFS_STAT, 8'h00);
    wr(SMC_OFS_CTRL, 8'hff);
    wr(4'h8, 8'h5a);
    rd(4'h8, 8'h00);
    rd(SMC_OFS_CTRL, 8'h7f);
    wr(SMC_OFS_CTRL, 8'h00);
    go(0);
    check(outs, 10'h311);
    wr(SMC_OFS_CTRL, 8'h63);
    go(0);
    check(outs, 10'h0cc);
    go(1);
    wake(2);
    check(outs, 10'h391);
    rd(SMC_OFS_STAT, 8'h11);
    rd(SMC_OFS_CTRL, 8'h00);
    wr(SMC_OFS_CTRL, 8'h80);
    rd(SMC_OFS_STAT, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(SMC_OFS_CTRL, cfg[i]);
      go(0);
      check(outs, expOut[i]);
      if (i == 0) begin
        go(1);
        go(2);
        check({8'h0, dbgAllCmdsEn_q, cpuRun_q}, 10'h002);
        go(1);
        go(3);
      end else begin
        wake(1);
        rd(SMC_OFS_CTRL, cfg[i]);
      end
      check(outs, 10'h311);
    end
    for (int j = 0; j < 7; j++) begin
      wr(SMC_OFS_CTRL, 8'h01);
      go(0);
      check(outs, 10'h02e);
      wake(j);
      check(outs, 10'h311);
    end
    check(10'(nWake), 10'h008);
    check(10'(nRst), 10'h002);
    check(10'(nErr), 10'h002);
    check(10'(nGrant), 10'h001);
    check(10'(nIll), 10'h001);
    conclude();
  end
endmodule
`default_nettype wire
